// *** inc/pesw_cfg.svh ***
// Register map, bit positions and reset values for the error status word block
`ifndef PESW_CFG_SVH
`define PESW_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PESW_OFF_STATUS    12'h000
`define PESW_OFF_MASK      12'h004
`define PESW_OFF_IRQ_STAT  12'h008
`define PESW_OFF_IRQ_MASK  12'h00C
`define PESW_OFF_CLEAR     12'h010

// ----------------------------------------------------------------------------
// Status word bit numbers, bit 0 is the leftmost position
// ----------------------------------------------------------------------------
`define PESW_B_SPEC        0
`define PESW_B_INV_ADDR    1
`define PESW_B_PRIV        2
`define PESW_B_PROT        3
`define PESW_B_INV_FUNC    4
`define PESW_B_FLOAT       5
`define PESW_B_STACK       6
`define PESW_B_EXT_ADDR    7
`define PESW_B_PARITY      8
`define PESW_B_UNUSED      9
`define PESW_B_PROC_CTL    10
`define PESW_B_IO_CHECK    11
`define PESW_B_SEQ         12
`define PESW_B_AUTO_IPL    13
`define PESW_B_XLATE       14
`define PESW_B_POWER       15

// ----------------------------------------------------------------------------
// Groups in register order (register bit = 15 - status bit)
// ----------------------------------------------------------------------------
`define PESW_PROG_GROUP    16'hFE00
`define PESW_HW_GROUP      16'h00B0
`define PESW_STAT_GROUP    16'h010F
`define PESW_UNUSED_MASK   16'h0040

// Register position of a status bit number
`define PESW_AT(b)         (15 - (b))

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PESW_RST_WORD      16'h0000
`define PESW_RST_MASK      3'h0

// Interrupt status bit positions
`define PESW_IRQ_PROG      0
`define PESW_IRQ_MCHK      1
`define PESW_IRQ_POWER     2

`endif

// *** inc/pesw_pkg.sv ***
// Types shared by the error status word block
`default_nettype none
package pesw_pkg;
  typedef enum logic [1:0] {
    PESW_RD_IDLE = 2'b00,
    PESW_RD_RESP = 2'b01
  } pesw_rd_state_t;

  typedef enum logic [1:0] {
    PESW_WR_IDLE = 2'b00,
    PESW_WR_RESP = 2'b01
  } pesw_wr_state_t;

  typedef logic [15:0] pesw_word_t;
endpackage
`default_nettype wire

// *** rtl/pesw_bit_map.sv ***
// Maps status bit numbers to register positions, bit 0 is the most significant
`timescale 1ns/1ps
`default_nettype none
`include "pesw_cfg.svh"

module pesw_bit_map (
  input  wire logic [15:0] events,
  output logic      [15:0] word
);
  // ----------------------------------------------------------------------------
  // Reverse bit order
  // ----------------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      word[15 - i] = events[i];
    end
  end
endmodule // pesw_bit_map
`default_nettype wire

// *** rtl/pesw_word_reg.sv ***
// Sticky capture register for the error status word
`timescale 1ns/1ps
`default_nettype none
`include "pesw_cfg.svh"

module pesw_word_reg (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] set_bits,
  input  wire logic [15:0] level_bits,
  input  wire logic [15:0] clr_bits,
  output logic      [15:0] word
);
  // ----------------------------------------------------------------------------
  // Sticky faults, level status; set wins over clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      word <= `PESW_RST_WORD;
    else
      word <= (((word & ~clr_bits) | set_bits) & (`PESW_PROG_GROUP | `PESW_HW_GROUP))
            | (level_bits & `PESW_STAT_GROUP);
  end
endmodule // pesw_word_reg
`default_nettype wire

// *** rtl/pesw_top.sv ***
// Processor error status word with AXI4-Lite access and interrupt outputs
// Function
// - Bit 0: misalignment or odd address
// - Bit 1: address beyond partition or none
// - Bit 2: privileged instruction in problem state
// - Bit 3: access to protected storage
// - Bit 4: illegal opcode or absent feature
// - Bit 5: floating-point under/overflow, divide check
// - Bit 6: stack empty pop, full push, overflow
// - Bits 0-6 form the program fault group
// - Bits 8, 10, 11 form hardware faults
// - Hardware faults raise machine check interrupt
// - Bits 7, 12-15 are level status only, but a rise of bit 15 (power warning) raises the power interrupt
// - Bit 0 is the most significant bit
`timescale 1ns/1ps
`default_nettype none
`include "pesw_cfg.svh"

module pesw_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Program fault events
  input  wire logic        align_fault,
  input  wire logic        odd_addr_fault,
  input  wire logic        beyond_partition,
  input  wire logic        no_partition,
  input  wire logic        priv_instr,
  input  wire logic        problem_state,
  input  wire logic        protect_fault,
  input  wire logic        illegal_opcode,
  input  wire logic        absent_feature,
  input  wire logic        fp_underflow,
  input  wire logic        fp_overflow,
  input  wire logic        fp_divide_check,
  input  wire logic        stack_pop_empty,
  input  wire logic        stack_push_full,
  input  wire logic        store_multiple_instr_ovf,
  // Hardware fault events
  input  wire logic        storage_parity,
  input  wire logic        proc_control_fault,
  input  wire logic        io_check,
  // Status levels
  input  wire logic        ext_addr_mode,
  input  wire logic        io_seq_ind,
  input  wire logic        auto_ipl,
  input  wire logic        xlate_enabled,
  input  wire logic        power_warning,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupts
  output logic             program_check_irq,
  output logic             machine_check_irq,
  output logic             irq
);
  // ----------------------------------------------------------------------------
  // Event gathering in status bit numbering
  // ----------------------------------------------------------------------------
  logic [15:0] ev_num;
  logic [15:0] lv_num;
  logic [15:0] ev_word;
  logic [15:0] lv_word;
  logic [15:0] status_word;
  logic [15:0] clr_word;
  logic [15:0] next_clr;

  always_comb
  begin
    ev_num = '0;
    lv_num = '0;
    ev_num[`PESW_B_SPEC]     = align_fault | odd_addr_fault;
    ev_num[`PESW_B_INV_ADDR] = beyond_partition | no_partition;
    ev_num[`PESW_B_PRIV]     = priv_instr & problem_state;
    ev_num[`PESW_B_PROT]     = protect_fault;
    ev_num[`PESW_B_INV_FUNC] = illegal_opcode | absent_feature;
    ev_num[`PESW_B_FLOAT]    = fp_underflow | fp_overflow | fp_divide_check;
    ev_num[`PESW_B_STACK]    = stack_pop_empty | stack_push_full
                             | store_multiple_instr_ovf;
    ev_num[`PESW_B_PARITY]   = storage_parity;
    ev_num[`PESW_B_PROC_CTL] = proc_control_fault;
    ev_num[`PESW_B_IO_CHECK] = io_check;
    lv_num[`PESW_B_EXT_ADDR] = ext_addr_mode;
    lv_num[`PESW_B_SEQ]      = io_seq_ind;
    lv_num[`PESW_B_AUTO_IPL] = auto_ipl;
    lv_num[`PESW_B_XLATE]    = xlate_enabled;
    lv_num[`PESW_B_POWER]    = power_warning;
  end

  pesw_bit_map u_map_ev (
    .events (ev_num),
    .word   (ev_word)
  );

  pesw_bit_map u_map_lv (
    .events (lv_num),
    .word   (lv_word)
  );

  pesw_word_reg u_word (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .set_bits   (ev_word),
    .level_bits (lv_word),
    .clr_bits   (clr_word),
    .word       (status_word)
  );

  // ----------------------------------------------------------------------------
  // Fault group summaries
  // ----------------------------------------------------------------------------
  function automatic logic any_in(input logic [15:0] w, input logic [15:0] grp);
    any_in = |(w & grp);
  endfunction

  logic prog_new;
  logic hw_new;
  logic pwr_rise;
  logic pwr_q;
  assign prog_new = any_in(ev_word, `PESW_PROG_GROUP);
  assign hw_new   = any_in(ev_word, `PESW_HW_GROUP);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwr_q <= 1'b0;
    else
      pwr_q <= power_warning;
  end
  assign pwr_rise = power_warning & ~pwr_q;

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic        irq_stat_rd;
  logic        mask_wr;
  logic        clr_wr;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_have;
  logic        w_have;
  pesw_pkg::pesw_wr_state_t wr_state;
  pesw_pkg::pesw_rd_state_t rd_state;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= `PESW_RST_MASK;
    else
      irq_stat <= (irq_stat & ~{3{irq_stat_rd}})
                | {pwr_rise, hw_new, prog_new};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= `PESW_RST_MASK;
    else if (mask_wr && w_strb[0])
      irq_mask <= w_data[2:0];
  end

  // Write of ones to the clear register drops sticky fault bits
  always_comb
  begin
    next_clr = '0;
    if (clr_wr)
    begin
      if (w_strb[0])
        next_clr[7:0] = w_data[7:0];
      if (w_strb[1])
        next_clr[15:8] = w_data[15:8];
    end
  end
  assign clr_word = next_clr & ~`PESW_UNUSED_MASK;

  // ----------------------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_check_irq <= 1'b0;
      machine_check_irq <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      program_check_irq <= any_in(status_word, `PESW_PROG_GROUP);
      machine_check_irq <= any_in(status_word, `PESW_HW_GROUP);
      irq               <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------------
  logic wr_go;
  assign wr_go   = (wr_state == pesw_pkg::PESW_WR_IDLE) && aw_have && w_have;
  assign mask_wr = wr_go && (aw_addr == `PESW_OFF_IRQ_MASK);
  assign clr_wr  = wr_go && (aw_addr == `PESW_OFF_CLEAR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      wr_state      <= pesw_pkg::PESW_WR_IDLE;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      else if (!aw_have && s_axi_awvalid && wr_state == pesw_pkg::PESW_WR_IDLE)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (!w_have && s_axi_wvalid && wr_state == pesw_pkg::PESW_WR_IDLE)
        s_axi_wready <= 1'b1;
      unique case (wr_state)
        pesw_pkg::PESW_WR_IDLE:
        begin
          if (wr_go)
          begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (mask_wr || clr_wr) ? 2'b00 : 2'b10;
            wr_state     <= pesw_pkg::PESW_WR_RESP;
          end
        end
        pesw_pkg::PESW_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state     <= pesw_pkg::PESW_WR_IDLE;
          end
        end
        default: wr_state <= pesw_pkg::PESW_WR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------------
  logic [11:0] rd_addr;
  assign rd_addr     = {s_axi_araddr[11:2], 2'b00};
  assign irq_stat_rd = s_axi_arvalid && s_axi_arready && (rd_addr == `PESW_OFF_IRQ_STAT);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
      rd_state      <= pesw_pkg::PESW_RD_IDLE;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      unique case (rd_state)
        pesw_pkg::PESW_RD_IDLE:
        begin
          if (s_axi_arvalid && s_axi_arready)
          begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            unique case (rd_addr)
              `PESW_OFF_STATUS:   s_axi_rdata <= {16'h0000, status_word};
              `PESW_OFF_MASK:     s_axi_rdata <= {16'h0000, `PESW_PROG_GROUP};
              `PESW_OFF_IRQ_STAT: s_axi_rdata <= {29'h000_0000, irq_stat};
              `PESW_OFF_IRQ_MASK: s_axi_rdata <= {29'h000_0000, irq_mask};
              default:
              begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
              end
            endcase
            rd_state <= pesw_pkg::PESW_RD_RESP;
          end
          else if (s_axi_arvalid)
            s_axi_arready <= 1'b1;
        end
        pesw_pkg::PESW_RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= pesw_pkg::PESW_RD_IDLE;
          end
        end
        default: rd_state <= pesw_pkg::PESW_RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_spec_bit_set: assert property (@(posedge aclk) disable iff (!aresetn)
    odd_addr_fault |=> status_word[`PESW_AT(`PESW_B_SPEC)]) else $error("spec bit not set");
  a_inv_addr_set: assert property (@(posedge aclk) disable iff (!aresetn)
    no_partition |=> status_word[`PESW_AT(`PESW_B_INV_ADDR)]) else $error("addr bit not set");
  a_priv_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (priv_instr && !problem_state && !status_word[`PESW_AT(`PESW_B_PRIV)] && !clr_wr)
    |=> !status_word[`PESW_AT(`PESW_B_PRIV)]) else $error("privilege set in supervisor state");
  a_protect_set: assert property (@(posedge aclk) disable iff (!aresetn)
    protect_fault |=> status_word[`PESW_AT(`PESW_B_PROT)]) else $error("protect bit not set");
  a_func_set: assert property (@(posedge aclk) disable iff (!aresetn)
    absent_feature |=> status_word[`PESW_AT(`PESW_B_INV_FUNC)]) else $error("func bit not set");
  a_float_set: assert property (@(posedge aclk) disable iff (!aresetn)
    fp_divide_check |=> status_word[`PESW_AT(`PESW_B_FLOAT)]) else $error("float bit not set");
  a_stack_set: assert property (@(posedge aclk) disable iff (!aresetn)
    store_multiple_instr_ovf |=> status_word[`PESW_AT(`PESW_B_STACK)])
    else $error("stack bit not set");
  a_mchk_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    io_check |=> ##1 machine_check_irq) else $error("machine check missing");
  a_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !status_word[`PESW_AT(`PESW_B_UNUSED)]) else $error("unused bit set");
  a_status_level: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(auto_ipl) |=> !status_word[`PESW_AT(`PESW_B_AUTO_IPL)]) else $error("status sticky");
endmodule // pesw_top
`default_nettype wire

// *** tb/pesw_core_model.sv ***
// Behavioural processor core that drives fault lines and status levels
`timescale 1ns/1ps
`default_nettype none

module pesw_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [16:0] req,
  input  wire logic [5:0]  lvl,
  output logic      [16:0] fault,
  output logic      [5:0]  stat
);
  // ---------------------------------------------------------------------
  // Lines follow the requests one edge later, quiet during reset
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault <= '0;
      stat  <= '0;
    end
    else
    begin
      fault <= req;
      stat  <= lvl;
    end
  end
endmodule // pesw_core_model
`default_nettype wire

// *** tb/tb_pesw_top.sv ***
// Self-checking bench for the error status word block
`timescale 1ns/1ps
`default_nettype none
`include "pesw_cfg.svh"

module tb_pesw_top;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [16:0] req     = '0;
  logic [5:0]  lvl     = '0;
  logic [16:0] flt;
  logic [5:0]  st;
  logic [11:0] awaddr  = '0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = '0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = '0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic        pc_irq;
  logic        mc_irq;
  logic        irq;
  logic [31:0] rdv;
  logic [1:0]  rsp;
  int          fails       = 0;
  int          checks_done = 0;
  int          fbit [17]   = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 5, 6, 6, 6, 8, 10, 11};

  initial
  begin
    forever #25 aclk = ~aclk;
  end

  pesw_core_model i_pesw_core_model (
    .aclk(aclk), .aresetn(aresetn), .req(req), .lvl(lvl), .fault(flt), .stat(st)
  );

  pesw_top i_pesw_top (
    .aclk(aclk), .aresetn(aresetn),
    .align_fault(flt[0]), .odd_addr_fault(flt[1]), .beyond_partition(flt[2]),
    .no_partition(flt[3]), .priv_instr(flt[4]), .problem_state(st[0]),
    .protect_fault(flt[5]), .illegal_opcode(flt[6]), .absent_feature(flt[7]),
    .fp_underflow(flt[8]), .fp_overflow(flt[9]), .fp_divide_check(flt[10]),
    .stack_pop_empty(flt[11]), .stack_push_full(flt[12]),
    .store_multiple_instr_ovf(flt[13]), .storage_parity(flt[14]),
    .proc_control_fault(flt[15]), .io_check(flt[16]),
    .ext_addr_mode(st[1]), .io_seq_ind(st[2]), .auto_ipl(st[3]),
    .xlate_enabled(st[4]), .power_warning(st[5]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .program_check_irq(pc_irq), .machine_check_irq(mc_irq), .irq(irq)
  );

  // ---------------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  // ---------------------------------------------------------------------
  // Bus cycles; handshakes observed at the falling edge before the taking edge
  // ---------------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic fa;
    logic fw;
    logic fb;
    int   n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      fa  = awvalid && awready;
      fw  = wvalid && wready;
      fb  = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (fa)
        awvalid <= 1'b0;
      if (fw)
        wvalid <= 1'b0;
      if (fb)
        break;
    end
    bready <= 1'b0;
    if (n == 40)
    begin
      fails++;
      summarize();
    end
  endtask

  task automatic rd(input logic [11:0] a);
    logic fa;
    logic fb;
    int   n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      fa  = arvalid && arready;
      fb  = rvalid;
      rdv = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (fa)
        arvalid <= 1'b0;
      if (fb)
        break;
    end
    rready <= 1'b0;
    if (n == 40)
    begin
      fails++;
      summarize();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a);
    chk(rdv, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    wr(a, d);
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  task automatic settle;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic pulse(input int k);
    @(posedge aclk);
    req <= 17'(1) << k;
    @(posedge aclk);
    req <= '0;
    settle();
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs;
    rd_chk(`PESW_OFF_STATUS, 32'h0, 2'b00);
    rd_chk(`PESW_OFF_MASK, 32'h0000_FE00, 2'b00);
    rd_chk(`PESW_OFF_IRQ_MASK, 32'h0, 2'b00);
    rd_chk(`PESW_OFF_IRQ_STAT, 32'h0, 2'b00);
  endtask

  task automatic t_faults;
    int          k;
    logic [31:0] want;
    @(posedge aclk);
    lvl <= 6'h01;
    for (k = 0; k < 17; k++)
    begin
      pulse(k);
      chk1(pc_irq, fbit[k] < 7);
      chk1(mc_irq, fbit[k] > 7);
      want = 32'(16'h8000 >> fbit[k]);
      rd_chk(`PESW_OFF_STATUS, want, 2'b00);
      rd_chk(`PESW_OFF_IRQ_STAT, (fbit[k] < 7) ? 32'h1 : 32'h2, 2'b00);
      wr_chk(`PESW_OFF_CLEAR, 32'h0000_FFFF, 2'b00);
      rd_chk(`PESW_OFF_STATUS, 32'h0, 2'b00);
    end
    @(posedge aclk);
    lvl <= 6'h00;
    pulse(4);
    rd_chk(`PESW_OFF_STATUS, 32'h0, 2'b00);
  endtask

  task automatic t_levels;
    @(posedge aclk);
    lvl <= 6'h3E;
    settle();
    chk1(pc_irq | mc_irq, 1'b0);
    rd_chk(`PESW_OFF_STATUS, 32'h0000_010F, 2'b00);
    rd_chk(`PESW_OFF_IRQ_STAT, 32'h4, 2'b00);
    @(posedge aclk);
    lvl <= 6'h00;
    settle();
    rd_chk(`PESW_OFF_STATUS, 32'h0, 2'b00);
  endtask

  task automatic t_refuse;
    wr_chk(`PESW_OFF_STATUS, 32'h0000_FFFF, 2'b10);
    wr_chk(`PESW_OFF_MASK, 32'h0, 2'b10);
    wr_chk(12'h020, 32'h0, 2'b10);
    rd_chk(`PESW_OFF_STATUS, 32'h0, 2'b00);
    rd_chk(12'h020, 32'h0, 2'b10);
  endtask

  task automatic t_irq;
    wr_chk(`PESW_OFF_IRQ_MASK, 32'h1, 2'b00);
    rd_chk(`PESW_OFF_IRQ_MASK, 32'h1, 2'b00);
    pulse(16);
    chk1(irq, 1'b0);
    chk1(mc_irq, 1'b1);
    wr_chk(`PESW_OFF_IRQ_MASK, 32'h2, 2'b00);
    settle();
    chk1(irq, 1'b1);
    rd_chk(`PESW_OFF_IRQ_STAT, 32'h2, 2'b00);
    settle();
    chk1(irq, 1'b0);
    wr_chk(`PESW_OFF_CLEAR, 32'h0000_FFFF, 2'b00);
    settle();
    chk1(mc_irq, 1'b0);
  endtask

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_faults();
    t_levels();
    t_refuse();
    t_irq();
    summarize();
  end
endmodule // tb_pesw_top
`default_nettype wire
